// ---- sim/i2c_master_model.sv ----
// bus master model that clocks and frames transfers to the control port
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
  parameter int H = 160
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o     = 1'b1; // clock stands high outside frames
    sda_low_o = 1'b0;
  end
  // start or repeated start from idle or clock low
  task automatic start();
    #(H) sda_low_o = 1'b0;
    #(H) scl_o = 1'b1;
    #(H) sda_low_o = 1'b1; // data falls while clock high
    #(H) scl_o = 1'b0;
  endtask
  task automatic stop();
    #(H/2) sda_low_o = 1'b1;
    #(H) scl_o = 1'b1;
    #(H) sda_low_o = 1'b0; // data rises while clock high
    #(H);
  endtask
  task automatic bit_out(input logic b);
    #(H/2) sda_low_o = ~b; // data moves only while clock low
    #(H/2) scl_o = 1'b1; // master makes every clock pulse
    #(H) scl_o = 1'b0;
  endtask
  task automatic send_bits(input logic [7:0] b, input int nb);
    for (int i = 7; i > 7 - nb; i--) bit_out(b[i]); // msb first
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    send_bits(b, 8);
    #(H/2) sda_low_o = 1'b0; // transmitter lets go for the ninth clock
    #(H/2) scl_o = 1'b1;
    #(H/2) ack = (sda_i === 1'b0);
    #(H/2) scl_o = 1'b0;
  endtask
  task automatic recv_byte(output logic [7:0] b, input logic ack);
    sda_low_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #(H) scl_o = 1'b1;
      #(H/2) b[i] = sda_i;
      #(H/2) scl_o = 1'b0;
    end
    bit_out(~ack); // single byte, closed by acknowledge when ack is set, else not-acknowledge
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_regulator_i2c_control_port.sv ----
// self-checking bench for the regulator serial control port
`timescale 1ns/100ps
`default_nettype none
module tb_regulator_i2c_control_port;
  import reg_port_pkg::*;
  localparam logic [6:0] ADDR     = 7'h2a; // value arbitrary
  localparam logic [4:0] DEF_CODE = 5'h0e;
  localparam logic [7:0] OV       = OUTPUT_VOLTAGE_CONTROL_ADDR;
  localparam logic [7:0] RR       = RAMP_RATE_CONTROL_ADDR;
  logic       core_clk_i, arst_n_i, chip_enable_i, auto_pfm_mode_i, power_up_done_i;
  logic       scl, m_low, sda_o, sda_oe_o, quiet, reconfig;
  logic [4:0] level, last_level, tgt;
  logic [2:0] ramp, ak;
  logic [7:0] v, d;
  wire logic  sda_line;
  int         mismatches = 0, comparisons = 0, cyc = 0, rc_cnt = 0, rc_cyc = 0, lvl_cyc = 0, n;
  assign sda_line = ((sda_oe_o === 1'b1 && sda_o === 1'b0) || m_low === 1'b1) ? 1'b0 : 1'b1;
  i2c_master_model u_m (.sda_i(sda_line), .scl_o(scl), .sda_low_o(m_low));
  regulator_i2c_control_port #(.SLAVE_ADDR(ADDR), .DEFAULT_LEVEL_CODE(DEF_CODE),
    .DEFAULT_QUIET_PFM(1'b0)) u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .chip_enable_i(chip_enable_i), .auto_pfm_mode_i(auto_pfm_mode_i),
    .power_up_done_i(power_up_done_i), .output_level_code_o(level),
    .quiet_pfm_select_o(quiet), .ramp_step_delay_o(ramp), .reconfig_o(reconfig));
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    last_level <= level;
    if (reconfig === 1'b1) begin
      rc_cnt <= rc_cnt + 1;
      rc_cyc <= cyc;
    end
    if (level !== last_level) lvl_cyc <= cyc;
  end
  function automatic int step_n(input logic [2:0] c);
    int ns [8] = '{0, 1500, 3100, 6300, 12500, 25000, 50000, 100000};
    return (ns[c] + 39) / 40;
  endfunction
  function automatic logic [7:0] exp_level(input logic [7:0] r);
    return {3'h0, r[7] ? r[4:0] : DEF_CODE};
  endfunction
  task automatic summarize();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask
  // whole write frame, data byte cut after nb bits when nb is below 8
  task automatic frame(input logic [7:0] id, input logic [7:0] ra, input logic [7:0] dt,
                       input int nb, output logic [2:0] a);
    @(posedge core_clk_i);
    #1;
    u_m.start();
    u_m.send_byte(id, a[2]);
    u_m.send_byte(ra, a[1]);
    a[0] = 1'b0;
    if (nb == 8) u_m.send_byte(dt, a[0]);
    else u_m.send_bits(dt, nb);
    u_m.stop();
    settle();
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] dt);
    n = rc_cnt;
    frame({ADDR, 1'b0}, ra, dt, 8, ak);
    check({5'h0, ak}, 8'h07, "write acks");
    check(8'(rc_cnt - n), 8'h01, "reconfig pulses");
  endtask
  task automatic rb(input logic [7:0] ra, input logic sep, input logic [7:0] exp);
    @(posedge core_clk_i);
    #1;
    u_m.start();
    u_m.send_byte({ADDR, 1'b0}, ak[2]);
    u_m.send_byte(ra, ak[1]);
    if (sep) u_m.stop();
    u_m.start();
    u_m.send_byte({ADDR, 1'b1}, ak[0]);
    u_m.recv_byte(d, 1'b0);
    u_m.stop();
    settle();
    check({5'h0, ak}, 8'h07, "read acks");
    check(d, exp, "read data");
  endtask
  initial begin
    #2000000;
    mismatches++;
    summarize();
  end
  initial begin
    void'($urandom(22));
    arst_n_i = 1'b0;
    chip_enable_i = 1'b1;
    auto_pfm_mode_i = 1'b1;
    power_up_done_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    arst_n_i = 1'b1;
    check({3'h0, level}, {3'h0, DEF_CODE}, "reset level");
    check({7'h0, quiet}, 8'h00, "reset quiet");
    check({5'h0, ramp}, 8'h00, "reset ramp");
    check({7'h0, sda_oe_o}, 8'h00, "reset data drive");
    settle();
    rb(OV, 1'b0, 8'h00);
    rb(RR, 1'b1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      if (i == 0) v = 8'hbf;
      if (i == 1) v = 8'h80;
      if (i == 2) v[7] = 1'b0;
      if (i == 3) v = v | 8'ha0;
      auto_pfm_mode_i = (i == 3) ? 1'b0 : (i == 0) ? 1'b1 : 1'($urandom);
      wr(OV, v);
      check({3'h0, level}, exp_level(v), "level");
      check({7'h0, quiet}, {7'h0, v[7] & v[5] & auto_pfm_mode_i}, "quiet");
      rb(OV, i[0], v[7] ? v : 8'h00);
    end
    n = rc_cnt;
    frame({ADDR ^ 7'h01, 1'b0}, OV, 8'h81, 8, ak);
    check({5'h0, ak}, 8'h00, "foreign id acks");
    frame({ADDR, 1'b0}, OV, 8'h81, 0, ak);
    check({5'h0, ak}, 8'h06, "no data acks");
    frame({ADDR, 1'b0}, OV, 8'h81, 5, ak);
    chip_enable_i = 1'b0;
    frame({ADDR, 1'b0}, OV, 8'h81, 8, ak);
    check({5'h0, ak}, 8'h00, "disabled acks");
    chip_enable_i = 1'b1;
    power_up_done_i = 1'b0;
    frame({ADDR, 1'b0}, OV, 8'h81, 8, ak);
    check({5'h0, ak}, 8'h00, "powering acks");
    power_up_done_i = 1'b1;
    check(8'(rc_cnt - n), 8'h00, "refused reconfig");
    check({3'h0, level}, exp_level(v), "kept level");
    auto_pfm_mode_i = 1'b1;
    wr(OV, 8'h90);
    for (int c = 0; c < 8; c++) begin
      v = {5'($urandom), 3'(c)};
      wr(RR, v);
      check({5'h0, ramp}, {5'h0, v[2:0]}, "ramp field");
      rb(RR, 1'b0, v);
      tgt = c[0] ? 5'h10 : 5'h11;
      wr(OV, {3'b100, tgt});
      n = 0;
      while (level !== tgt && n < 3000) begin
        @(posedge core_clk_i);
        #1;
        n++;
      end
      @(posedge core_clk_i);
      #1;
      check({3'h0, level}, {3'h0, tgt}, "ramp target");
      n = lvl_cyc - rc_cyc;
      check({7'h0, n >= step_n(3'(c)) - 1 && n <= step_n(3'(c)) + 2}, 8'h01, "step delay");
    end
    summarize();
  end
endmodule
`default_nettype wire

// ---- verilog/line_sync.sv ----
// two-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none

module line_sync #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= RESET_VALUE;
      sync_o   <= RESET_VALUE;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ---- verilog/reg_port_pkg.sv ----
// constants, register map and timing for the regulator serial control port
package reg_port_pkg;

  // register map
  localparam logic [7:0] OUTPUT_VOLTAGE_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] RAMP_RATE_CONTROL_ADDR      = 8'h01;
  localparam logic [7:0] OUTPUT_VOLTAGE_RESET        = 8'h00;
  localparam logic [7:0] RAMP_RATE_RESET             = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE         = 8'h00;

  // field layout
  localparam int LEVEL_CODE_MSB     = 4;
  localparam int QUIET_PFM_BIT      = 5;
  localparam int WRITE_UNLOCK_BIT   = 7;
  localparam int RAMP_DELAY_MSB     = 2;
  localparam int LEVEL_CODE_WIDTH   = LEVEL_CODE_MSB + 1;
  localparam int RAMP_DELAY_WIDTH   = RAMP_DELAY_MSB + 1;

  // serial byte framing
  localparam int             BYTE_BITS   = 8;
  localparam logic [3:0]     BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]     BIT_CNT_ZERO  = 4'h0;
  localparam logic           SDA_LOW       = 1'b0;

  // synchroniser lanes: {auto_pfm_mode, chip_enable, sda, scl}
  localparam int         SYNC_WIDTH = 4;
  localparam int         LANE_SCL   = 0;
  localparam int         LANE_SDA   = 1;
  localparam int         LANE_EN    = 2;
  localparam int         LANE_MODE  = 3;
  localparam logic [3:0] SYNC_RESET = 4'hb;

  // ramp step delay per one-code change, in ns
  localparam int CLK_PERIOD_NS = 40;
  localparam int STEP_NS_1     = 1500;
  localparam int STEP_NS_2     = 3100;
  localparam int STEP_NS_3     = 6300;
  localparam int STEP_NS_4     = 12500;
  localparam int STEP_NS_5     = 25000;
  localparam int STEP_NS_6     = 50000;
  localparam int STEP_NS_7     = 100000;
  localparam int STEP_CNT_WIDTH = 12;

  localparam logic [11:0] STEP_CYC_1 = 12'((STEP_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_2 = 12'((STEP_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_3 = 12'((STEP_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_4 = 12'((STEP_NS_4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_5 = 12'((STEP_NS_5 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_6 = 12'((STEP_NS_6 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_7 = 12'((STEP_NS_7 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] STEP_CYC_0 = 12'h000;
  localparam logic [11:0] STEP_CNT_ONE = 12'h001;

  function automatic logic [11:0] step_cycles(input logic [2:0] code);
    logic [11:0] cyc;
    cyc = STEP_CYC_0;
    case (code)
      3'h1:    cyc = STEP_CYC_1;
      3'h2:    cyc = STEP_CYC_2;
      3'h3:    cyc = STEP_CYC_3;
      3'h4:    cyc = STEP_CYC_4;
      3'h5:    cyc = STEP_CYC_5;
      3'h6:    cyc = STEP_CYC_6;
      3'h7:    cyc = STEP_CYC_7;
      default: cyc = STEP_CYC_0;
    endcase
    return cyc;
  endfunction

endpackage

// ---- verilog/regulator_i2c_control_port.sv ----
// serial slave control port with output-voltage and ramp-rate registers
`timescale 1ns/100ps
`default_nettype none

// Function
// - unlock set: apply last accepted level settings
// - no accepted write: apply factory default settings
// - write with unlock zero: revert to default
// - level code selects 1.9V plus code tenths
// - ramp field sets delay per code step
// - slave only; master starts and clocks all
// - bytes shift most significant bit first
// - sda change with scl high: start/stop
// - after power-up sda released as input
// - ignore starts while powering up or disabled
// - stop after valid write triggers reconfiguration
// - transmitter releases sda; receiver acks ninth clock
// - ack matching id, register and data bytes
// - id byte: slave address plus direction bit
// - stop before data byte+ack discards command
// - read: addr write, restart, id read, byte
// - bit 5 quiet pfm, ignored under forced pwm
module regulator_i2c_control_port
  import reg_port_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR         = 7'h2a, // value arbitrary
  parameter logic [4:0] DEFAULT_LEVEL_CODE = 5'h0e,
  parameter logic       DEFAULT_QUIET_PFM  = 1'b0
) (
  input  wire logic                                   core_clk_i,
  input  wire logic                                   arst_n_i,
  input  wire logic                                   scl_i,
  input  wire logic                                   sda_i,
  output logic                                        sda_o,
  output logic                                        sda_oe_o,
  input  wire logic                                   chip_enable_i,
  input  wire logic                                   auto_pfm_mode_i,
  input  wire logic                                   power_up_done_i,
  output logic [reg_port_pkg::LEVEL_CODE_MSB:0]       output_level_code_o,
  output logic                                        quiet_pfm_select_o,
  output logic [reg_port_pkg::RAMP_DELAY_MSB:0]       ramp_step_delay_o,
  output logic                                        reconfig_o
);
  import reg_port_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ID, ST_ACK_ID, ST_REG, ST_ACK_REG, ST_WDATA,
    ST_ACK_DATA, ST_RDATA, ST_RACK, ST_WAIT_STOP
  } port_state_e;

  port_state_e                     state_reg;
  logic [SYNC_WIDTH-1:0]           pins_sync;
  logic                            scl_prev_reg, sda_prev_reg, scl_s, sda_s;
  logic                            bus_active, forced_pwm;
  logic                            scl_rise, scl_fall, start_det, stop_det, bit_in, byte_done;
  logic [3:0]                      bit_cnt_reg;
  logic [7:0]                      shift_reg, tx_reg, ptr_reg, staged_reg;
  logic                            is_read_reg, wr_done_reg, oe_reg;
  logic [7:0]                      output_voltage_control, ramp_rate_control, rd_byte;
  logic [LEVEL_CODE_MSB:0]         target_code, level_reg;
  logic                            target_quiet, quiet_reg, reconfig_reg;
  logic [STEP_CNT_WIDTH-1:0]       delay_cnt_reg, step_cyc;

  line_sync #(
    .WIDTH       (SYNC_WIDTH),
    .RESET_VALUE (SYNC_RESET)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .async_i    ({auto_pfm_mode_i, chip_enable_i, sda_i, scl_i}),
    .sync_o     (pins_sync)
  );

  assign scl_s      = pins_sync[LANE_SCL];
  assign sda_s      = pins_sync[LANE_SDA];
  assign forced_pwm = ~pins_sync[LANE_MODE];
  assign bus_active = pins_sync[LANE_EN] & power_up_done_i;

  // edge detection on the synchronised lines
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_prev_reg <= SYNC_RESET[LANE_SCL];
      sda_prev_reg <= SYNC_RESET[LANE_SDA];
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign bit_in    = scl_rise & (bit_cnt_reg != BITS_PER_BYTE);
  assign byte_done = scl_fall & (bit_cnt_reg == BITS_PER_BYTE);

  // read data selection
  always_comb begin
    rd_byte = UNMAPPED_READ_VALUE;
    if (ptr_reg == OUTPUT_VOLTAGE_CONTROL_ADDR) begin
      rd_byte = output_voltage_control;
    end else if (ptr_reg == RAMP_RATE_CONTROL_ADDR) begin
      rd_byte = ramp_rate_control;
    end
  end

  // serial protocol engine, slave only
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= BIT_CNT_ZERO;
      shift_reg   <= '0;
      tx_reg      <= '0;
      ptr_reg     <= OUTPUT_VOLTAGE_CONTROL_ADDR;
      staged_reg  <= '0;
      is_read_reg <= 1'b0;
      wr_done_reg <= 1'b0;
      oe_reg      <= 1'b0;
    end else if (!bus_active) begin
      state_reg   <= ST_IDLE;
      oe_reg      <= 1'b0;
      wr_done_reg <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ST_ID;
      bit_cnt_reg <= BIT_CNT_ZERO;
      oe_reg      <= 1'b0;
      wr_done_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg   <= ST_IDLE;
      oe_reg      <= 1'b0;
      wr_done_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ID, ST_REG, ST_WDATA: begin
          if (bit_in) begin
            shift_reg   <= {shift_reg[BYTE_BITS-2:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= BIT_CNT_ZERO;
            if (state_reg == ST_ID) begin
              if (shift_reg[BYTE_BITS-1:1] == SLAVE_ADDR) begin
                oe_reg      <= 1'b1;
                is_read_reg <= shift_reg[0];
                state_reg   <= ST_ACK_ID;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (state_reg == ST_REG) begin
              ptr_reg   <= shift_reg;
              oe_reg    <= 1'b1;
              state_reg <= ST_ACK_REG;
            end else begin
              staged_reg <= shift_reg;
              oe_reg     <= 1'b1;
              state_reg  <= ST_ACK_DATA;
            end
          end
        end
        ST_ACK_ID: begin
          if (scl_fall) begin
            if (is_read_reg) begin
              oe_reg    <= ~rd_byte[BYTE_BITS-1];
              tx_reg    <= {rd_byte[BYTE_BITS-2:0], 1'b0};
              state_reg <= ST_RDATA;
            end else begin
              oe_reg    <= 1'b0;
              state_reg <= ST_REG;
            end
          end
        end
        ST_ACK_REG: begin
          if (scl_fall) begin
            oe_reg    <= 1'b0;
            state_reg <= ST_WDATA;
          end
        end
        ST_ACK_DATA: begin
          if (scl_fall) begin
            oe_reg      <= 1'b0;
            wr_done_reg <= 1'b1;
            state_reg   <= ST_WAIT_STOP;
          end
        end
        ST_RDATA: begin
          if (bit_in) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= BIT_CNT_ZERO;
            oe_reg      <= 1'b0;
            state_reg   <= ST_RACK;
          end else if (scl_fall) begin
            oe_reg <= ~tx_reg[BYTE_BITS-1];
            tx_reg <= {tx_reg[BYTE_BITS-2:0], 1'b0};
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            state_reg <= ST_WAIT_STOP;
          end
        end
        ST_IDLE, ST_WAIT_STOP: begin
          oe_reg <= 1'b0;
        end
        default: begin
          state_reg <= ST_IDLE;
          oe_reg    <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o    = SDA_LOW;
  assign sda_oe_o = oe_reg;

  // register commit at the stop that ends a complete write
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      output_voltage_control <= OUTPUT_VOLTAGE_RESET;
      ramp_rate_control      <= RAMP_RATE_RESET;
      reconfig_reg           <= 1'b0;
    end else begin
      reconfig_reg <= 1'b0;
      if (bus_active && stop_det && wr_done_reg) begin
        reconfig_reg <= 1'b1;
        if (ptr_reg == OUTPUT_VOLTAGE_CONTROL_ADDR) begin
          if (staged_reg[WRITE_UNLOCK_BIT]) begin
            output_voltage_control <= staged_reg;
          end else begin
            output_voltage_control <= OUTPUT_VOLTAGE_RESET;
          end
        end else if (ptr_reg == RAMP_RATE_CONTROL_ADDR) begin
          ramp_rate_control <= staged_reg;
        end
      end
    end
  end

  // applied setting: last accepted when unlocked, factory default otherwise
  assign target_code  = output_voltage_control[WRITE_UNLOCK_BIT] ?
                        output_voltage_control[LEVEL_CODE_MSB:0] : DEFAULT_LEVEL_CODE;
  assign target_quiet = output_voltage_control[WRITE_UNLOCK_BIT] ?
                        output_voltage_control[QUIET_PFM_BIT] : DEFAULT_QUIET_PFM;
  assign step_cyc     = step_cycles(ramp_rate_control[RAMP_DELAY_MSB:0]);

  // level code ramp, one code step per programmed delay
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_reg     <= DEFAULT_LEVEL_CODE;
      delay_cnt_reg <= '0;
    end else if (level_reg == target_code) begin
      delay_cnt_reg <= '0;
    end else if (step_cyc == STEP_CYC_0) begin
      level_reg     <= target_code;
      delay_cnt_reg <= '0;
    end else if (delay_cnt_reg >= step_cyc - STEP_CNT_ONE) begin
      delay_cnt_reg <= '0;
      if (target_code > level_reg) begin
        level_reg <= level_reg + 5'h01;
      end else begin
        level_reg <= level_reg - 5'h01;
      end
    end else begin
      delay_cnt_reg <= delay_cnt_reg + STEP_CNT_ONE;
    end
  end

  // quiet pfm has no effect under forced pwm
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      quiet_reg <= DEFAULT_QUIET_PFM;
    end else begin
      quiet_reg <= target_quiet & ~forced_pwm;
    end
  end

  assign output_level_code_o = level_reg;
  assign quiet_pfm_select_o  = quiet_reg;
  assign ramp_step_delay_o   = ramp_rate_control[RAMP_DELAY_MSB:0];
  assign reconfig_o          = reconfig_reg;

  // checks
  chk_disabled_idle: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !bus_active |=> state_reg == ST_IDLE && !sda_oe_o)
    else $error("port not idle while disabled");
  chk_idle_released: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    state_reg == ST_IDLE |-> !sda_oe_o)
    else $error("sda driven while idle");
  chk_drive_slave_only: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    sda_oe_o |-> state_reg inside {ST_ACK_ID, ST_ACK_REG, ST_ACK_DATA, ST_RDATA})
    else $error("sda driven outside slave slots");
  chk_ack_release: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    bus_active && state_reg == ST_ACK_DATA && scl_fall && !start_det && !stop_det
    |=> !sda_oe_o && wr_done_reg)
    else $error("ack not released on ninth clock fall");
  chk_nack_mismatch: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    bus_active && !start_det && !stop_det && state_reg == ST_ID && byte_done
    && shift_reg[7:1] != SLAVE_ADDR |=> state_reg == ST_IDLE && !sda_oe_o)
    else $error("mismatched address acknowledged");
  chk_ack_match: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    bus_active && !start_det && !stop_det && state_reg == ST_ID && byte_done
    && shift_reg[7:1] == SLAVE_ADDR |=> sda_oe_o ##1 sda_oe_o)
    else $error("matching address not acknowledged");
  chk_commit_on_stop: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    reconfig_o |-> $past(stop_det) && $past(wr_done_reg))
    else $error("reconfiguration without complete write and stop");
  chk_partial_discard: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    stop_det && !wr_done_reg |=> !reconfig_o
    && $stable(output_voltage_control) && $stable(ramp_rate_control))
    else $error("partial write changed settings");
  chk_locked_default: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    reconfig_o && $past(ptr_reg) == OUTPUT_VOLTAGE_CONTROL_ADDR
    && !$past(staged_reg[WRITE_UNLOCK_BIT]) |-> target_code == DEFAULT_LEVEL_CODE)
    else $error("protected write did not revert to default");
  chk_level_step: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    $past(step_cyc) != STEP_CYC_0 && level_reg != $past(level_reg)
    |-> $past(delay_cnt_reg) == $past(step_cyc) - STEP_CNT_ONE
    && (level_reg == $past(level_reg) + 5'h01 || level_reg == $past(level_reg) - 5'h01))
    else $error("ramp step timing or size wrong");
  chk_quiet_forced: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    forced_pwm |=> !quiet_pfm_select_o)
    else $error("quiet pfm active under forced pwm");

  cov_write_commit: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    reconfig_o && output_voltage_control[WRITE_UNLOCK_BIT]);
  cov_read_byte: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    state_reg == ST_RACK);
  cov_ramp_step: cover property (@(posedge core_clk_i) disable iff (!arst_n_i)
    step_cyc != STEP_CYC_0 && level_reg != target_code ##1 level_reg == target_code);

endmodule

`default_nettype wire
